// ==== spdp_host_model.sv ====
// Purpose: host driving the serial configuration lines
// Assumes: serial clock period 160 ns
// Notes:   data line flips between frames
`timescale 1ns/10ps
module spdp_host_model (
    input  wire  ref_clk_i, lock_or_serial_out_i,
    output logic serial_enable_line_o = 1'b0, serial_clk_o = 1'b0, serial_in_line_o = 1'b0
);
    task frame(input logic rw, input logic [5:0] a, input logic [23:0] d, output logic [23:0] q);
        logic [31:0] v;
        v = {rw, a, d, 1'b0};
        q = 24'h0;
        @(negedge ref_clk_i);
        serial_enable_line_o = 1'b1;
        serial_in_line_o = rw;
        #80;
        for (int i = 1; i <= 32; i++) begin
            serial_clk_o = 1'b1;
            #80;
            serial_clk_o = 1'b0;
            if (i >= 8 && i <= 31) q = {q[22:0], lock_or_serial_out_i};
            serial_in_line_o = (i < 32) ? v[31 - i] : ~v[0];
            #80;
        end
        serial_enable_line_o = 1'b0;
        #400;
    endtask
    task clk_first;
        @(negedge ref_clk_i);
        serial_clk_o = 1'b1;
        #80;
        serial_clk_o = 1'b0;
        #400;
    endtask
endmodule // spdp_host_model

// ==== spdp_map.vh ====
// Purpose: constants for the dual protocol serial configuration port
// Assumes: included by spdp_port.v only
// Notes:   frame positions count rising serial clock edges from 1
`ifndef SPDP_MAP_VH
`define SPDP_MAP_VH
`define SPDP_REG_ID_RDSEL   6'h00
`define SPDP_ADDR_W         6
`define SPDP_DATA_W         24
`define SPDP_POS_RW         6'h01
`define SPDP_POS_ADDR_LAST  6'h07
`define SPDP_POS_DATA_FIRST 6'h08
`define SPDP_POS_DATA_LAST  6'h1F
`define SPDP_POS_COMMIT     6'h20
`define SPDP_OPEN_AW        5
`define SPDP_OPEN_SRST_BIT  5
`define SPDP_PROTO_NONE     2'h0
`define SPDP_PROTO_SINGLE   2'h1
`define SPDP_PROTO_MULTI    2'h2
`define SPDP_CHIP_ID        24'hA5A5A5
`endif

// ==== spdp_port.v ====
// Purpose: serial configuration port with power-on protocol choice
// Assumes: serial lines are asynchronous and much slower than ref_clk_i
// Notes:   multi-target framing is left to outside logic; only its choice is made here
`timescale 1ns/10ps
`include "spdp_map.vh"
module spdp_port #(
    parameter CHIP_ID = `SPDP_CHIP_ID  // arbitrary value
) (
    // clock and reset
    input  wire        ref_clk_i,
    input  wire        arst_n_i,
    // serial pins
    input  wire        serial_enable_line_i,
    input  wire        serial_clk_i,
    input  wire        serial_in_line_i,
    output reg         lock_or_serial_out_o,
    // core side
    input  wire        lock_indicator_i,
    input  wire [23:0] rd_data_i,
    output reg  [5:0]  rd_addr_o,
    output reg         wr_stb_o,
    output reg  [5:0]  wr_addr_o,
    output reg  [23:0] wr_data_o,
    output reg         soft_rst_o,
    output reg  [17:0] gen_strobe_o,
    output reg  [4:0]  open_rd_addr_o,
    output reg  [1:0]  proto_o
);
    // pin order inside the sampler bank
    localparam NPIN    = 3;
    localparam PIN_SEN = 0;
    localparam PIN_SCK = 1;
    localparam PIN_SDI = 2;

    wire [NPIN-1:0] pin_raw;
    wire [NPIN-1:0] pin_s3;
    wire [NPIN-1:0] pin_lvl;
    wire [NPIN-1:0] pin_rise;

    assign pin_raw = {serial_in_line_i, serial_clk_i, serial_enable_line_i};

    genvar g;
    generate
        for (g = 0; g < NPIN; g = g + 1) begin : g_pin
            // three-stage sampler; stage 1 is read only by stage 2
            reg [2:0] sync_r;
            reg       lvl_r;
            always @(posedge ref_clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    sync_r <= 3'h0;
                    lvl_r  <= 1'b0;
                end else begin
                    sync_r <= {sync_r[1:0], pin_raw[g]};
                    // a change counts once stages 2 and 3 agree
                    if (sync_r[1] == sync_r[2]) begin
                        lvl_r <= sync_r[2];
                    end
                end
            end
            assign pin_s3[g]   = sync_r[2];
            assign pin_lvl[g]  = lvl_r;
            assign pin_rise[g] = (sync_r[1] == sync_r[2]) && sync_r[2] && !lvl_r;
        end
    endgenerate

    wire sen_lvl  = pin_lvl[PIN_SEN];
    wire sen_rise = pin_rise[PIN_SEN];
    wire sck_rise = pin_rise[PIN_SCK];
    wire sdi_now  = pin_s3[PIN_SDI];

    // register zero is decoded for both read and write
    function is_reg_zero;
        input [5:0] a;
        begin
            is_reg_zero = (a == `SPDP_REG_ID_RDSEL);
        end
    endfunction

    // protocol choice cleared on power-on reset only, never on soft reset
    reg [1:0] proto_r;
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            proto_r <= `SPDP_PROTO_NONE;
        end else if (proto_r == `SPDP_PROTO_NONE) begin
            if (sen_rise) begin
                proto_r <= `SPDP_PROTO_SINGLE;
            end else if (sck_rise) begin
                proto_r <= `SPDP_PROTO_MULTI;
            end
        end
    end
    always @* proto_o = proto_r;

    // single-target frame engine
    reg  [5:0]  pos_r;
    reg         rd_r;
    reg  [5:0]  addr_r;
    reg  [23:0] sh_r;
    reg  [23:0] rsh_r;
    reg         out_sel_r;
    // no chip address: one device owns the bus in this protocol
    wire        single    = (proto_r == `SPDP_PROTO_SINGLE);
    wire        active    = single && sen_lvl;
    wire [5:0]  pos_nxt   = pos_r + 6'h01;
    wire [5:0]  addr_nxt  = {addr_r[4:0], sdi_now};
    // edges past the commit are ignored until enable drops
    wire        step      = active && sck_rise && (pos_r != `SPDP_POS_COMMIT);
    wire        at_rw     = step && (pos_nxt == `SPDP_POS_RW);
    wire        in_addr   = step && (pos_nxt != `SPDP_POS_RW) && (pos_nxt <= `SPDP_POS_ADDR_LAST);
    wire        in_data   = step && (pos_nxt > `SPDP_POS_ADDR_LAST) && (pos_nxt <= `SPDP_POS_DATA_LAST);
    wire        at_commit = step && (pos_nxt == `SPDP_POS_COMMIT);

    // position, command bit, address and write data capture
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pos_r     <= 6'h00;
            rd_r      <= 1'b0;
            addr_r    <= 6'h00;
            sh_r      <= 24'h000000;
            rd_addr_o <= 6'h00;
        end else begin
            if (!active) begin
                pos_r <= 6'h00;
            end else if (step) begin
                pos_r <= pos_nxt;
            end
            if (at_rw) begin
                rd_r <= sdi_now;
            end
            if (in_addr) begin
                addr_r <= addr_nxt;
            end
            // core gets the read address before data edge eight
            if (in_addr && (pos_nxt == `SPDP_POS_ADDR_LAST)) begin
                rd_addr_o <= addr_nxt;
            end
            if (in_data) begin
                sh_r <= {sh_r[22:0], sdi_now};
            end
        end
    end

    // read data shifter and output select
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rsh_r     <= 24'h000000;
            out_sel_r <= 1'b0;
        end else if (!active) begin
            out_sel_r <= 1'b0;
        end else if (in_data && rd_r) begin
            out_sel_r <= 1'b1;
            if (pos_nxt == `SPDP_POS_DATA_FIRST) begin
                rsh_r <= is_reg_zero(addr_r) ? CHIP_ID : rd_data_i;
            end else begin
                rsh_r <= {rsh_r[22:0], 1'b0};
            end
        end else if (at_commit) begin
            out_sel_r <= 1'b0;
        end
    end

    // commit of a write frame; strobes last one cycle
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_stb_o       <= 1'b0;
            wr_addr_o      <= 6'h00;
            wr_data_o      <= 24'h000000;
            soft_rst_o     <= 1'b0;
            gen_strobe_o   <= 18'h00000;
            open_rd_addr_o <= 5'h00;
        end else begin
            wr_stb_o     <= 1'b0;
            soft_rst_o   <= 1'b0;
            gen_strobe_o <= 18'h00000;
            if (at_commit && !rd_r) begin
                if (is_reg_zero(addr_r)) begin
                    soft_rst_o     <= sh_r[`SPDP_OPEN_SRST_BIT];
                    gen_strobe_o   <= sh_r[23:6];
                    open_rd_addr_o <= sh_r[4:0];
                end else begin
                    wr_stb_o  <= 1'b1;
                    wr_addr_o <= addr_r;
                    wr_data_o <= sh_r;
                end
            end
        end
    end

    // shared output: lock detect unless read data is being shifted out
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lock_or_serial_out_o <= 1'b0;
        end else begin
            lock_or_serial_out_o <= out_sel_r ? rsh_r[23] : lock_indicator_i;
        end
    end

endmodule // spdp_port

// ==== spdp_port_properties.sv ====
// Purpose: port checks for spdp_port
// Assumes: one clock domain, async active-low reset
// Notes:   bound to every spdp_port instance
`timescale 1ns/10ps
module spdp_port_properties (
    // clock, reset and pins
    input wire        ref_clk_i, arst_n_i, serial_enable_line_i, lock_indicator_i, lock_or_serial_out_o,
    // core side
    input wire        wr_stb_o, soft_rst_o,
    input wire [5:0]  wr_addr_o,
    input wire [17:0] gen_strobe_o,
    input wire [1:0]  proto_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_idle;
        !serial_enable_line_i [*8];
    endsequence
    a_proto_sticky: assert property (proto_o != 2'h0 |=> $stable(proto_o)) else $error("protocol moved");
    a_proto_legal: assert property (proto_o != 2'h3) else $error("bad protocol code");
    a_pick_single: assert property (proto_o == 2'h1 && $past(proto_o) == 2'h0 |-> serial_enable_line_i)
        else $error("single chosen without enable");
    a_multi_quiet: assert property (proto_o == 2'h2 |-> !wr_stb_o) else $error("write in multi mode");
    a_wr_single: assert property (wr_stb_o |-> proto_o == 2'h1 && wr_addr_o != 6'h00)
        else $error("bad write strobe");
    a_wr_pulse: assert property (wr_stb_o |=> !wr_stb_o && $stable(wr_addr_o)) else $error("write pulse");
    a_soft_pulse: assert property (soft_rst_o |=> !soft_rst_o) else $error("soft reset pulse");
    a_gen_pulse: assert property (gen_strobe_o != 18'h0 |=> gen_strobe_o == 18'h0) else $error("strobe");
    a_lock_idle: assert property (s_idle ##0 proto_o != 2'h2 |-> lock_or_serial_out_o == $past(lock_indicator_i))
        else $error("lock not shown");
endmodule // spdp_port_properties
bind spdp_port spdp_port_properties i_spdp_port_properties (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .serial_enable_line_i(serial_enable_line_i), .lock_indicator_i(lock_indicator_i),
    .lock_or_serial_out_o(lock_or_serial_out_o), .wr_stb_o(wr_stb_o), .soft_rst_o(soft_rst_o),
    .wr_addr_o(wr_addr_o), .gen_strobe_o(gen_strobe_o), .proto_o(proto_o));

// ==== spdp_port_tb.sv ====
// Purpose: self-checking bench for spdp_port
// Assumes: host model drives the serial lines
// Notes:   read data is a pattern of the read address
`timescale 1ns/10ps
module spdp_port_tb;
    localparam logic [23:0] ID = 24'h3C5A96; // arbitrary value
    logic ref_clk_i = 1'b0, arst_n_i = 1'b0, lock = 1'b0, serial_enable_line, sck, serial_in_line, sdo, stb, srst;
    logic [5:0] rd_addr, wr_addr;
    logic [23:0] wr_data, q;
    logic [17:0] gen, gen_seen = 18'h0;
    logic [4:0] open_addr;
    logic [1:0] proto;
    int failures = 0, cmp_count = 0, n_wr = 0, n_srst = 0;
    wire [23:0] rd_data = {rd_addr, ~rd_addr, rd_addr, 6'h2D};
    always #5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        n_wr += stb;
        n_srst += srst;
        if (|gen) gen_seen = gen;
    end
    spdp_port #(.CHIP_ID(ID)) i_spdp_port (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .serial_enable_line_i(serial_enable_line),
        .serial_clk_i(sck), .serial_in_line_i(serial_in_line), .lock_or_serial_out_o(sdo), .lock_indicator_i(lock),
        .rd_data_i(rd_data), .rd_addr_o(rd_addr), .wr_stb_o(stb), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
        .soft_rst_o(srst), .gen_strobe_o(gen), .open_rd_addr_o(open_addr), .proto_o(proto));
    spdp_host_model i_spdp_host_model (.ref_clk_i(ref_clk_i), .lock_or_serial_out_i(sdo),
        .serial_enable_line_o(serial_enable_line), .serial_clk_o(sck), .serial_in_line_o(serial_in_line));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task summarize;
        $display("failures %0d comparisons %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task do_reset;
        arst_n_i = 1'b0;
        repeat (5) @(negedge ref_clk_i);
        arst_n_i = 1'b1;
        repeat (5) @(negedge ref_clk_i);
    endtask
    initial begin
        #300000;
        failures++;
        summarize;
    end
    initial begin
        do_reset;
        chk(proto, 2'h0);
        i_spdp_host_model.frame(1'b0, 6'h2A, 24'h5C3A91, q);
        chk({proto, wr_addr, wr_data}, {2'h1, 6'h2A, 24'h5C3A91});
        chk(n_wr, 1);
        i_spdp_host_model.frame(1'b1, 6'h3F, 24'h0, q);
        chk(q, {6'h3F, 6'h00, 6'h3F, 6'h2D});
        chk(rd_addr, 6'h3F);
        chk(n_wr, 1);
        lock = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        chk(sdo, 1'b1);
        i_spdp_host_model.frame(1'b1, 6'h00, 24'h0, q);
        chk(q, ID);
        i_spdp_host_model.frame(1'b0, 6'h00, 24'hFFFFE3, q);
        chk({n_srst[7:0], gen_seen, open_addr}, {8'h01, 18'h3FFFF, 5'h03});
        chk({proto, n_wr[7:0]}, {2'h1, 8'h01});
        do_reset;
        i_spdp_host_model.clk_first;
        i_spdp_host_model.frame(1'b0, 6'h2A, 24'h123456, q);
        chk(proto, 2'h2);
        chk(n_wr, 1);
        summarize;
    end
endmodule // spdp_port_tb
